/* logic/hpc_power_ctrl.sv */
// ----------------------------------------------------------------
// Summary of operation
// - drive active-low power-off request to the regulator that cuts chip power, block stays up.
// - in power-off, restore power on resume pin or counter match.
// - power-up is regulator turn-on time then a chip power-on reset.
// - back-to-back reads are accepted without any spacing.
// - reference input is used only while the oscillator enable bit is set.
// - select 0 divides 4.194304 MHz by 128; select 1 uses 32.768 kHz.
// - battery below 2.35 V is flagged by the comparator input.
// - in run state with detect enabled, low battery sets the raw battery event bit.
// - detect plus veto set refuses power-down while battery is low.
// - no battery measurement while powered off.
// - low battery can raise the interrupt through its mask.
// - power-down starts on request bit; no resume source needs to be armed.
// - pin and match resume enables arm their sources, either or both.
// - counter ticks once per second; trim used one second in 64.
// - masked events ored into one interrupt; write one to clear.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "hpc_regs.svh"

module hpc_power_ctrl
    import hpc_pkg::*;
#(
    parameter int REGON_CYC = (`HPC_REGON_NS + `HPC_CLK_NS - 1) / `HPC_CLK_NS,
    parameter int POR_CYC   = (`HPC_POR_NS + `HPC_CLK_NS - 1) / `HPC_CLK_NS
)
(
    // clock and reset
    input  wire logic            clock,
    input  wire logic            rst_n,
    input  wire logic            clk_en,
    // register port
    input  wire hpc_bus_req_type bus_req,
    output logic [31:0]          rd_data_ff,
    // pins
    input  wire logic            ref_clk_in,
    input  wire logic            resume_n,
    input  wire logic            battery_below_thresh,
    output logic                 power_off_request_out_n_ff,
    output logic                 chip_reset_n_ff,
    output logic                 irq_ff
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [7:0]     ctrl_ff,   nxt_ctrl;
    hpc_events_type raw_ff,    nxt_raw;
    hpc_events_type mask_ff,   nxt_mask;
    logic [31:0]    count_ff,  nxt_count;
    logic [31:0]    match_ff,  nxt_match;
    logic [15:0]    trim_ff,   nxt_trim;
    logic [31:0]    nxt_rd;
    logic           nxt_irq;

    // reference domain helpers (sampled as synchronous input)
    logic           ref_d_ff,  nxt_ref_d;
    logic [6:0]     xdiv_ff,   nxt_xdiv;
    logic [15:0]    pre_ff,    nxt_pre;
    logic [5:0]     sec_ff,    nxt_sec;
    logic [1:0]     settle_ff, nxt_settle;

    // power sequencing
    hpc_state_type  state_ff,  nxt_state;
    logic [31:0]    tmr_ff,    nxt_tmr;
    logic           nxt_off_n;
    logic           nxt_por_n;

    function automatic logic sel(input logic [7:0] a, input logic [7:0] ofs);
        sel = (a == ofs);
    endfunction

    logic ref_edge;
    logic ref_tick;
    logic sec_tick;
    logic matched;
    logic batt_low_seen;
    logic wr_ctrl;

    // ----------------------------------------------------------------
    // reference clock path
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_ref_d = ref_clk_in & ctrl_ff[`HPC_CTL_OSC_EN];
        ref_edge  = nxt_ref_d & ~ref_d_ff;
        nxt_xdiv  = xdiv_ff;
        ref_tick  = 1'b0;
        if (ref_edge)
        begin
            if (ctrl_ff[`HPC_CTL_OSC_SEL])
            begin
                ref_tick = 1'b1;
            end
            else
            begin
                nxt_xdiv = xdiv_ff + 7'h01;
                ref_tick = (xdiv_ff == `HPC_XTAL_DIV);
            end
        end
        // predivider counts down; trim reload once per 64 seconds
        nxt_pre  = pre_ff;
        nxt_sec  = sec_ff;
        sec_tick = 1'b0;
        if (ref_tick && ctrl_ff[`HPC_CTL_CNT_EN])
        begin
            if (pre_ff == 16'h0000)
            begin
                sec_tick = 1'b1;
                nxt_sec  = sec_ff + 6'h01;
                nxt_pre  = (sec_ff == `HPC_TRIM_PERIOD) ? trim_ff : `HPC_TRIM_RST;
            end
            else
            begin
                nxt_pre = pre_ff - 16'h0001;
            end
        end
        // write settling counted in reference ticks
        nxt_settle = settle_ff;
        if (wr_ctrl)
        begin
            nxt_settle = `HPC_SETTLE_EDGES;
        end
        else if (ref_tick && settle_ff != 2'h0)
        begin
            nxt_settle = settle_ff - 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // registers, events and read path
    // ----------------------------------------------------------------
    always_comb
    begin
        wr_ctrl     = bus_req.wr && sel(bus_req.addr, `HPC_OFS_CTRL);
        matched     = (count_ff == match_ff);
        // no measurement while powered off
        batt_low_seen = ctrl_ff[`HPC_CTL_BATDET_EN] && battery_below_thresh
                      && state_ff == HPC_RUN;
        nxt_ctrl  = ctrl_ff;
        nxt_mask  = mask_ff;
        nxt_match = match_ff;
        nxt_trim  = trim_ff;
        nxt_raw   = raw_ff;
        nxt_count = sec_tick ? count_ff + 32'h1 : count_ff;
        if (bus_req.wr)
        begin
            if (wr_ctrl)
            begin
                nxt_ctrl = bus_req.wdata[7:0];
            end
            if (sel(bus_req.addr, `HPC_OFS_MASK))
            begin
                nxt_mask = bus_req.wdata[2:0];
            end
            if (sel(bus_req.addr, `HPC_OFS_CLEAR))
            begin
                nxt_raw = raw_ff & ~bus_req.wdata[2:0];
            end
            if (sel(bus_req.addr, `HPC_OFS_COUNT))
            begin
                nxt_count = bus_req.wdata;
            end
            if (sel(bus_req.addr, `HPC_OFS_MATCH))
            begin
                nxt_match = bus_req.wdata;
            end
            if (sel(bus_req.addr, `HPC_OFS_TRIM))
            begin
                nxt_trim = bus_req.wdata[15:0];
            end
        end
        // set wins over clear
        if (sec_tick && nxt_count == match_ff)
        begin
            nxt_raw.match = 1'b1;
        end
        if (batt_low_seen)
        begin
            nxt_raw.battery_low_flag = 1'b1;
        end
        if (!resume_n)
        begin
            nxt_raw.pin = 1'b1;
        end
        // request bit self-clears once acted on or refused
        if (state_ff == HPC_RUN && ctrl_ff[`HPC_CTL_REQ])
        begin
            nxt_ctrl[`HPC_CTL_REQ] = 1'b0;
        end
        nxt_irq = |(nxt_raw & nxt_mask);
        nxt_rd  = 32'h0;
        if (bus_req.rd)
        begin
            // reads have no side effects, so any spacing works
            case (bus_req.addr)
                `HPC_OFS_CTRL:   nxt_rd = {(settle_ff != 2'h0), 23'h0, ctrl_ff};
                `HPC_OFS_RAW:    nxt_rd = {29'h0, raw_ff};
                `HPC_OFS_MASK:   nxt_rd = {29'h0, mask_ff};
                `HPC_OFS_MASKED: nxt_rd = {29'h0, raw_ff & mask_ff};
                `HPC_OFS_COUNT:  nxt_rd = count_ff;
                `HPC_OFS_MATCH:  nxt_rd = match_ff;
                `HPC_OFS_TRIM:   nxt_rd = {16'h0, trim_ff};
                default:         nxt_rd = 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // power sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_tmr   = tmr_ff;
        case (state_ff)
            HPC_RUN:
            begin
                // refuse while battery low with detect and veto set
                if (ctrl_ff[`HPC_CTL_REQ] &&
                    !(ctrl_ff[`HPC_CTL_BATDET_EN] && ctrl_ff[`HPC_CTL_VETO]
                      && battery_below_thresh))
                begin
                    nxt_state = HPC_OFF;
                end
            end
            HPC_OFF:
            begin
                if ((ctrl_ff[`HPC_CTL_PIN_WEN] && !resume_n) ||
                    (ctrl_ff[`HPC_CTL_MATCH_WEN] && matched))
                begin
                    nxt_state = HPC_REG_ON;
                    nxt_tmr   = 32'h0;
                end
            end
            HPC_REG_ON:
            begin
                nxt_tmr = tmr_ff + 32'h1;
                if (tmr_ff >= REGON_CYC[31:0] - 32'h1)
                begin
                    nxt_state = HPC_POR;
                    nxt_tmr   = 32'h0;
                end
            end
            HPC_POR:
            begin
                nxt_tmr = tmr_ff + 32'h1;
                if (tmr_ff >= POR_CYC[31:0] - 32'h1)
                begin
                    nxt_state = HPC_RUN;
                end
            end
            default:
            begin
                nxt_state = HPC_RUN;
            end
        endcase
        nxt_off_n = (nxt_state != HPC_OFF);
        nxt_por_n = (nxt_state == HPC_RUN);
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_ff                    <= 8'h00;
            raw_ff                     <= 3'h0;
            mask_ff                    <= 3'h0;
            count_ff                   <= 32'h0;
            match_ff                   <= 32'hffffffff;
            trim_ff                    <= `HPC_TRIM_RST;
            rd_data_ff                 <= 32'h0;
            irq_ff                     <= 1'b0;
            ref_d_ff                   <= 1'b0;
            xdiv_ff                    <= 7'h00;
            pre_ff                     <= `HPC_TRIM_RST;
            sec_ff                     <= 6'h00;
            settle_ff                  <= 2'h0;
            state_ff                   <= HPC_RUN;
            tmr_ff                     <= 32'h0;
            power_off_request_out_n_ff <= 1'b1;
            chip_reset_n_ff            <= 1'b1;
        end
        else if (clk_en)
        begin
            ctrl_ff                    <= nxt_ctrl;
            raw_ff                     <= nxt_raw;
            mask_ff                    <= nxt_mask;
            count_ff                   <= nxt_count;
            match_ff                   <= nxt_match;
            trim_ff                    <= nxt_trim;
            rd_data_ff                 <= nxt_rd;
            irq_ff                     <= nxt_irq;
            ref_d_ff                   <= nxt_ref_d;
            xdiv_ff                    <= nxt_xdiv;
            pre_ff                     <= nxt_pre;
            sec_ff                     <= nxt_sec;
            settle_ff                  <= nxt_settle;
            state_ff                   <= nxt_state;
            tmr_ff                     <= nxt_tmr;
            power_off_request_out_n_ff <= nxt_off_n;
            chip_reset_n_ff            <= nxt_por_n;
        end
    end

endmodule

/* logic/hpc_regs.svh */
`ifndef HPC_REGS_SVH
`define HPC_REGS_SVH
// register offsets (byte addresses)
`define HPC_OFS_CTRL      8'h00
`define HPC_OFS_RAW       8'h04
`define HPC_OFS_MASK      8'h08
`define HPC_OFS_MASKED    8'h0c
`define HPC_OFS_CLEAR     8'h10
`define HPC_OFS_COUNT     8'h14
`define HPC_OFS_MATCH     8'h18
`define HPC_OFS_TRIM      8'h1c
// control register fields
`define HPC_CTL_REQ       0
`define HPC_CTL_CNT_EN    1
`define HPC_CTL_OSC_SEL   2
`define HPC_CTL_MATCH_WEN 3
`define HPC_CTL_PIN_WEN   4
`define HPC_CTL_BATDET_EN 5
`define HPC_CTL_OSC_EN    6
`define HPC_CTL_VETO      7
`define HPC_CTL_BUSY      31
// event fields
`define HPC_EV_MATCH      0
`define HPC_EV_BATLOW     1
`define HPC_EV_PIN        2
// reset values and timing
`define HPC_TRIM_RST      16'h7fff
`define HPC_XTAL_DIV      7'h7f
`define HPC_TRIM_PERIOD   6'h3f
`define HPC_SETTLE_EDGES  2'h3
`define HPC_REGON_NS      32'd500000
`define HPC_POR_NS        32'd10000
`define HPC_CLK_NS        32'd25
`endif

/* logic/hpc_pkg.sv */
package hpc_pkg;
    typedef enum logic [1:0]
    {
        HPC_RUN      = 2'b00,
        HPC_OFF      = 2'b01,
        HPC_REG_ON   = 2'b10,
        HPC_POR      = 2'b11
    } hpc_state_type;

    typedef struct packed
    {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } hpc_bus_req_type;

    typedef struct packed
    {
        logic pin;
        logic battery_low_flag;
        logic match;
    } hpc_events_type;
endpackage

/* bench/hpc_power_ctrl_props.sv */
`timescale 1ns/1ps
`include "hpc_regs.svh"
module hpc_power_ctrl_props
    import hpc_pkg::*;
#(
    parameter int REGON_CYC = 4,
    parameter int POR_CYC   = 4
)
(
    // clock and reset
    input wire logic            clock,
    input wire logic            rst_n,
    input wire logic            clk_en,
    // register port
    input wire hpc_bus_req_type bus_req,
    input wire logic [31:0]     rd_data_ff,
    // pins
    input wire logic            ref_clk_in,
    input wire logic            resume_n,
    input wire logic            battery_below_thresh,
    input wire logic            power_off_request_out_n_ff,
    input wire logic            chip_reset_n_ff,
    input wire logic            irq_ff
);
    localparam logic [15:0] LO = 16'(REGON_CYC + POR_CYC - 1);
    localparam logic [15:0] HI = 16'(REGON_CYC + POR_CYC + 1);
    logic [3:0]  since_res_ff;
    logic [3:0]  nxt_since_res;
    logic [15:0] held_ff;
    logic [15:0] nxt_held;
    logic        req_wr;
    assign req_wr = bus_req.wr && bus_req.addr == `HPC_OFS_CTRL && bus_req.wdata[0];
    // saturating age of the last resume pulse, and length of the power-up hold
    always_comb
    begin
        nxt_since_res = !resume_n ? 4'h0 : since_res_ff + {3'h0, since_res_ff != 4'hf};
        nxt_held = !power_off_request_out_n_ff ? 16'h0 : held_ff + {15'h0, !chip_reset_n_ff};
    end
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            since_res_ff <= 4'hf;
            held_ff <= 16'h0;
        end
        else
        begin
            since_res_ff <= nxt_since_res;
            held_ff <= nxt_held;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_idle_read_zero: assert property (!$past(bus_req.rd) |-> rd_data_ff == 32'h0)
        else $error("read data outside the answer cycle");
    a_unmapped_zero: assert property ($past(bus_req.rd && bus_req.addr >= 8'h20)
        |-> rd_data_ff == 32'h0) else $error("unmapped read not zero");
    a_clear_reads_zero: assert property ($past(bus_req.rd && bus_req.addr == `HPC_OFS_CLEAR)
        |-> rd_data_ff == 32'h0) else $error("clear register read not zero");
    a_off_holds_reset: assert property (!power_off_request_out_n_ff |-> !chip_reset_n_ff)
        else $error("chip out of reset while power is cut");
    a_entry_by_request: assert property ($fell(power_off_request_out_n_ff)
        |-> $past(req_wr, 1) || $past(req_wr, 2)) else $error("power cut without request");
    a_veto_refuses: assert property (req_wr && bus_req.wdata[5] && bus_req.wdata[7]
        && battery_below_thresh && power_off_request_out_n_ff
        |=> power_off_request_out_n_ff ##1 power_off_request_out_n_ff)
        else $error("power cut despite low battery veto");
    a_wake_has_cause: assert property ($rose(power_off_request_out_n_ff)
        |-> since_res_ff <= 4'h6) else $error("power restored without resume");
    a_asleep_stays_off: assert property (!power_off_request_out_n_ff && resume_n
        && since_res_ff > 4'h6 |=> !power_off_request_out_n_ff)
        else $error("power restored spontaneously");
    a_power_up_hold: assert property ($rose(power_off_request_out_n_ff)
        |=> !chip_reset_n_ff [*3]) else $error("chip reset released too early");
    a_por_length: assert property ($rose(chip_reset_n_ff) |-> held_ff >= LO && held_ff <= HI)
        else $error("power-up hold length wrong");
    a_masked_irq: assert property ($past(bus_req.rd && bus_req.addr == `HPC_OFS_MASKED)
        && rd_data_ff != 32'h0 |-> irq_ff || $past(irq_ff)) else $error("irq low with events");
endmodule

bind hpc_power_ctrl hpc_power_ctrl_props #(.REGON_CYC(REGON_CYC), .POR_CYC(POR_CYC)) u_props
(
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .bus_req(bus_req), .rd_data_ff(rd_data_ff),
    .ref_clk_in(ref_clk_in), .resume_n(resume_n), .battery_below_thresh(battery_below_thresh),
    .power_off_request_out_n_ff(power_off_request_out_n_ff),
    .chip_reset_n_ff(chip_reset_n_ff), .irq_ff(irq_ff)
);

/* bench/hpc_far_side.sv */
`timescale 1ns/1ps
module hpc_far_side
(
    // clock and command
    input  wire logic clock,
    input  wire logic wake_cmd,
    // pins
    input  wire logic power_off_request_out_n_ff,
    output logic      ref_clk_in,
    output logic      resume_n,
    output logic      rail_up
);
    logic [2:0] wake_cnt = 3'h0;
    initial ref_clk_in = 1'b0;
    // free-running oscillator, phase unrelated to clock
    always #103 ref_clk_in = ~ref_clk_in;
    // wake source pulls low for four cycles; weak pull-up otherwise
    always @(posedge clock)
        wake_cnt <= wake_cmd ? 3'h4 : wake_cnt - {2'h0, wake_cnt != 3'h0};
    assign resume_n = wake_cnt == 3'h0;
    // regulator output follows its enable one cycle late
    always @(posedge clock)
        rail_up <= power_off_request_out_n_ff;
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
`include "hpc_regs.svh"
module testbench
    import hpc_pkg::*;
();
    logic            clock = 1'b0;
    logic            rst_n = 1'b0;
    hpc_bus_req_type bus_req = '0;
    logic            batt = 1'b0;
    logic            wake_cmd = 1'b0;
    logic            clk_en = 1'b1;
    logic [31:0]     rd_data_ff;
    logic            ref_clk, resume_n, off_n, crst_n, irq, rail_up;
    int              bad_count = 0;
    int              comparisons = 0;
    int              cycles = 0;
    int              exp_raw = 0;
    int              exp_mask = 0;
    logic [31:0]     seed = 32'd66;
    logic [31:0]     d0, d1, r0, r1;
    always #12.5 clock = ~clock;
    hpc_power_ctrl #(.REGON_CYC(4), .POR_CYC(4)) dut
    (
        .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .bus_req(bus_req), .rd_data_ff(rd_data_ff),
        .ref_clk_in(ref_clk), .resume_n(resume_n), .battery_below_thresh(batt),
        .power_off_request_out_n_ff(off_n), .chip_reset_n_ff(crst_n), .irq_ff(irq)
    );
    hpc_far_side far
    (
        .clock(clock), .wake_cmd(wake_cmd), .power_off_request_out_n_ff(off_n),
        .ref_clk_in(ref_clk), .resume_n(resume_n), .rail_up(rail_up)
    );
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req <= '0;
    endtask
    // two reads on consecutive edges, no gap between them
    // bit 32 of an expectation set means no compare
    task automatic chk2(input logic [7:0] a, input logic [32:0] ea,
                        input logic [7:0] b, input logic [32:0] eb);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req <= '{addr: b, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        #1 r0 = rd_data_ff;
        @(posedge clock);
        bus_req <= '0;
        #1 r1 = rd_data_ff;
        if (!ea[32]) check(r0, ea[31:0]);
        if (!eb[32]) check(r1, eb[31:0]);
    endtask
    // poll the busy bit: control writes need time to reach the reference domain
    task automatic wrs(input logic [7:0] a, input logic [31:0] d);
        wr(a, d);
        r1 = 32'hffff_ffff;
        for (int n = 0; n < 100 && r1[31] !== 1'b0; n++) chk2(`HPC_OFS_CTRL, -1, `HPC_OFS_CTRL, -1);
        check({31'h0, r1[31]}, 32'h0);
    endtask
    task automatic irq_chk();
        check({31'h0, irq}, {31'h0, |(exp_raw & exp_mask)});
    endtask
    task automatic wait_off(input logic v);
        for (int i = 0; i < 100 && off_n !== v; i++) @(posedge clock);
        #1 check({31'h0, off_n}, {31'h0, v});
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            wrap_up();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        chk2(`HPC_OFS_TRIM, 32'h7fff, `HPC_OFS_MATCH, 32'hffff_ffff);
        chk2(`HPC_OFS_CTRL, 0, 8'h20, 0);
        wr(`HPC_OFS_CTRL, 32'h40);
        // divided path: three ticks of 128 reference edges, about 3160 cycles
        repeat (3000) @(posedge clock);
        chk2(`HPC_OFS_CTRL, 32'h8000_0040, `HPC_OFS_CTRL, 32'h8000_0040);
        repeat (200) @(posedge clock);
        chk2(`HPC_OFS_CTRL, 32'h40, `HPC_OFS_RAW, 0);
        wrs(`HPC_OFS_CTRL, 32'h44);
        chk2(`HPC_OFS_CTRL, 32'h44, `HPC_OFS_RAW, 0);
        d0 = xorshift();
        d1 = xorshift();
        wrs(`HPC_OFS_COUNT, d0);
        wrs(`HPC_OFS_MATCH, d1);
        chk2(`HPC_OFS_COUNT, d0, `HPC_OFS_MATCH, d1);
        wrs(`HPC_OFS_CTRL, 32'h64);
        batt <= 1'b1;
        repeat (8) @(posedge clock);
        exp_raw = 2;
        for (int i = 0; i < 4; i++)
        begin
            exp_mask = (i == 3) ? 7 : int'(xorshift() & 32'h7);
            wr(`HPC_OFS_MASK, exp_mask);
            chk2(`HPC_OFS_RAW, exp_raw, `HPC_OFS_MASKED, exp_raw & exp_mask);
            irq_chk();
        end
        wr(`HPC_OFS_CLEAR, 32'h2);
        chk2(`HPC_OFS_RAW, exp_raw, `HPC_OFS_CLEAR, 0);
        batt <= 1'b0;
        wr(`HPC_OFS_CLEAR, 32'h2);
        exp_raw = 0;
        chk2(`HPC_OFS_RAW, exp_raw, `HPC_OFS_MASKED, 0);
        irq_chk();
        batt <= 1'b1;
        wrs(`HPC_OFS_CTRL, 32'hf4);
        wrs(`HPC_OFS_CTRL, 32'hf5);
        repeat (6) @(posedge clock);
        #1 check({31'h0, off_n}, 32'h1);
        batt <= 1'b0;
        wrs(`HPC_OFS_CTRL, 32'h74);
        wr(`HPC_OFS_CLEAR, 32'h7);
        wr(`HPC_OFS_CTRL, 32'h75);
        wait_off(1'b0);
        check({30'h0, off_n, crst_n}, 0);
        batt <= 1'b1;
        repeat (20) @(posedge clock);
        batt <= 1'b0;
        wake_cmd <= 1'b1;
        @(posedge clock);
        wake_cmd <= 1'b0;
        wait_off(1'b1);
        for (int i = 0; i < 100 && crst_n !== 1'b1; i++) @(posedge clock);
        check({30'h0, crst_n, rail_up}, 32'h3);
        exp_raw = 4;
        chk2(`HPC_OFS_RAW, exp_raw, `HPC_OFS_CTRL, 32'h74);
        irq_chk();
        // a low clock enable must drop the mask write
        @(posedge clock);
        clk_en <= 1'b0;
        wr(`HPC_OFS_MASK, 32'h0);
        clk_en <= 1'b1;
        chk2(`HPC_OFS_MASK, exp_mask, `HPC_OFS_MASKED, exp_raw & exp_mask);
        wrap_up();
    end
endmodule
